/* File: twi_status_pkg.sv */
// How it works
// - status bit 16 shows master enabled
// - status bit 14 sets on accepted stop, held until status_clear
// - status bit 13 sets on packet check mismatch, held until cleared
// - status bit 12 sets on bus timeout, held until cleared
// - status bit 11 sets on alert received, held until cleared
// - status bit 10 sets when a driven one is sampled low, held until cleared
// - status bit 9 sets on data byte nack, held until cleared
// - status bit 8 sets on address nack, held until cleared
// - status bit 5 is live bus free indication
// - status bit 4 high only when nothing executes or waits
// - status bit 3 sets on successful command, cleared by status_clear
// - status bit 2 high while a command slot can accept a command
// - status bit 1 high while tx_holding can accept data
// - status bit 0 high while a received byte waits
// - ones written to irq_enable_set set irq_mask bits
// - ones written to irq_enable_clear clear irq_mask bits
// - irq_mask enables per flag, read-only, resets to zero
// - status_clear ones clear bits 14..8 and 3 only
package twi_status_pkg;

  // ----------------------------------------
  // register byte addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_TX_HOLDING = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_ENABLE_SET = 8'h20;
  localparam logic [7:0] ADDR_IRQ_ENABLE_CLEAR = 8'h24;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h28;
  localparam logic [7:0] ADDR_STATUS_CLEAR = 8'h2C;

  // ----------------------------------------
  // status field positions
  // ----------------------------------------
  localparam int BIT_RECEIVE_READY = 0;
  localparam int BIT_TRANSMIT_READY = 1;
  localparam int BIT_COMMAND_SLOT_READY = 2;
  localparam int BIT_COMMAND_DONE = 3;
  localparam int BIT_IDLE = 4;
  localparam int BIT_BUS_FREE = 5;
  localparam int BIT_ADDRESS_NACK = 8;
  localparam int BIT_DATA_NACK = 9;
  localparam int BIT_ARBITRATION_LOST = 10;
  localparam int BIT_ALERT = 11;
  localparam int BIT_BUS_TIMEOUT = 12;
  localparam int BIT_PACKET_CHECK_ERROR = 13;
  localparam int BIT_STOP_ACCEPTED = 14;
  localparam int BIT_MASTER_ENABLED = 16;
  localparam int STICKY_COUNT = 7;

  // ----------------------------------------
  // masks and reset values
  // ----------------------------------------
  localparam logic [31:0] STATUS_CLEARABLE = 32'h00007F08;
  localparam logic [31:0] IRQ_MASK_WRITABLE = 32'h00007F3F;
  localparam logic [31:0] STATUS_RESET = 32'h00000002;
  localparam logic [31:0] IRQ_MASK_RESET = 32'h00000000;
  localparam logic [7:0] TX_HOLDING_RESET = 8'h00;

  // ----------------------------------------
  // ahb encodings
  // ----------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;

  // events from the protocol engine, one-cycle pulses
  typedef struct packed {
    logic stop_accepted;
    logic packet_check_error;
    logic bus_timeout;
    logic alert;
    logic address_nack;
    logic data_nack;
    logic command_ok;
  } engine_events_t;

  // live levels from the protocol engine
  typedef struct packed {
    logic master_enabled;
    logic bus_free;
    logic command_busy;
    logic command_queued;
    logic command_slot_free;
    logic tx_room;
    logic tx_stopped;
    logic rx_waiting;
  } engine_levels_t;

  // returns one for ahb transfer types that carry data
  function automatic logic is_active_trans(input logic [1:0] trans);
    return (trans == HTRANS_NONSEQ) || (trans == HTRANS_SEQ);
  endfunction

endpackage

/* File: twi_arb_watch.sv */
`timescale 1ns/10ps
`default_nettype none
// --------------------------------------------------
// arbitration watcher
// --------------------------------------------------
module twi_arb_watch
  import twi_status_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // data pin sampling
  input wire logic i_sda_sample,
  input wire logic i_sda_oe_n,
  input wire logic i_sda_out,
  input wire logic i_bit_sample,
  // result
  output logic o_lost
);

  // pulse when we drive a one onto sda but the wire reads low
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_lost <= 1'b0;
    end else begin
      o_lost <= i_bit_sample && !i_sda_oe_n && i_sda_out && !i_sda_sample;
    end
  end

endmodule
`default_nettype wire

/* File: twi_master_status_irq_regs.sv */
// Local design decision: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
// --------------------------------------------------
// status, mask and transmit register slave
// --------------------------------------------------
module twi_master_status_irq_regs
  import twi_status_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // protocol engine side
  input wire engine_events_t i_events,
  input wire engine_levels_t i_levels,
  input wire logic i_tx_taken,
  input wire logic i_sda_sample,
  input wire logic i_sda_oe_n,
  input wire logic i_sda_out,
  input wire logic i_bit_sample,
  output logic [7:0] o_byte_to_send,
  output logic o_byte_valid,
  output logic o_irq
);

  // --------------------------------------------------
  // address phase capture
  // --------------------------------------------------
  logic dp_write;
  logic rd_now;
  logic [7:0] rd_addr;
  logic [7:0] dp_addr;
  logic wr_tx;
  logic wr_set;
  logic wr_clr;
  logic wr_sclr;
  logic arb_lost;
  logic [STICKY_COUNT-1:0] sticky;
  logic command_done_flag;
  logic [31:0] status;
  logic [31:0] irq_mask;
  logic [31:0] next_hrdata;
  logic [STICKY_COUNT-1:0] sticky_set;

  // only whole-word writes are taken; other writes simply do nothing
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
    end else if (i_hready) begin
      dp_write <= i_hsel && is_active_trans(i_htrans) && i_hwrite && (i_hsize == 3'h2);
      dp_addr <= i_haddr[7:0];
    end
  end

  // zero-wait slave, always okay
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end
  end

  // data phase write strobes
  assign wr_tx = dp_write && (dp_addr == ADDR_TX_HOLDING);
  assign wr_set = dp_write && (dp_addr == ADDR_IRQ_ENABLE_SET);
  assign wr_clr = dp_write && (dp_addr == ADDR_IRQ_ENABLE_CLEAR);
  assign wr_sclr = dp_write && (dp_addr == ADDR_STATUS_CLEAR);

  // --------------------------------------------------
  // transmit holding byte
  // --------------------------------------------------
  // one-deep holding; a write while full overwrites, software should poll ready first
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_byte_to_send <= TX_HOLDING_RESET;
      o_byte_valid <= 1'b0;
    end else if (wr_tx) begin
      o_byte_to_send <= i_hwdata[7:0];
      o_byte_valid <= 1'b1;
    end else if (i_tx_taken) begin
      o_byte_valid <= 1'b0;
    end
  end

  // --------------------------------------------------
  // sticky event flags
  // --------------------------------------------------
  twi_arb_watch u_arb_watch (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_sda_sample(i_sda_sample),
    .i_sda_oe_n(i_sda_oe_n),
    .i_sda_out(i_sda_out),
    .i_bit_sample(i_bit_sample),
    .o_lost(arb_lost)
  );

  // sticky order is bits 8..14
  assign sticky_set = {i_events.stop_accepted, i_events.packet_check_error, i_events.bus_timeout,
                       i_events.alert, arb_lost, i_events.data_nack, i_events.address_nack};

  // set wins over a clear arriving in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < STICKY_COUNT; gi++) begin : g_sticky
      always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
          sticky[gi] <= 1'b0;
        end else if (sticky_set[gi]) begin
          sticky[gi] <= 1'b1;
        end else if (wr_sclr && i_hwdata[BIT_ADDRESS_NACK + gi]) begin
          sticky[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // a failed command never sets it, so only successes arrive here
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      command_done_flag <= 1'b0;
    end else if (i_events.command_ok) begin
      command_done_flag <= 1'b1;
    end else if (wr_sclr && i_hwdata[BIT_COMMAND_DONE]) begin
      command_done_flag <= 1'b0;
    end
  end

  // --------------------------------------------------
  // status register image, registered live levels
  // --------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      status <= STATUS_RESET;
    end else begin
      status <= 32'h00000000;
      status[BIT_MASTER_ENABLED] <= i_levels.master_enabled;
      status[BIT_STOP_ACCEPTED:BIT_ADDRESS_NACK] <= sticky;
      status[BIT_BUS_FREE] <= i_levels.bus_free;
      status[BIT_IDLE] <= !i_levels.command_busy && !i_levels.command_queued;
      status[BIT_COMMAND_DONE] <= command_done_flag;
      status[BIT_COMMAND_SLOT_READY] <= i_levels.command_slot_free;
      status[BIT_TRANSMIT_READY] <= i_levels.tx_room && !i_levels.tx_stopped;
      status[BIT_RECEIVE_READY] <= i_levels.rx_waiting;
    end
  end

  // --------------------------------------------------
  // interrupt mask
  // --------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_mask <= IRQ_MASK_RESET;
    end else if (wr_set) begin
      irq_mask <= irq_mask | (i_hwdata & IRQ_MASK_WRITABLE);
    end else if (wr_clr) begin
      irq_mask <= irq_mask & ~(i_hwdata & IRQ_MASK_WRITABLE);
    end
  end

  // registered request; follows status one cycle later, clearing the flag drops it
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(status & irq_mask);
    end
  end

  // --------------------------------------------------
  // read data
  // --------------------------------------------------
  // decode is taken in the address phase and the word launched at its end,
  // so it stands through the whole data phase
  assign rd_now = i_hready && i_hsel && is_active_trans(i_htrans) && !i_hwrite;
  assign rd_addr = i_haddr[7:0];

  // write-only and unmapped words read as zero
  always_comb begin
    next_hrdata = 32'h00000000;
    if (rd_now && rd_addr == ADDR_STATUS) begin
      next_hrdata = status;
    end else if (rd_now && rd_addr == ADDR_IRQ_MASK) begin
      next_hrdata = irq_mask;
    end
  end

  // reloaded every cycle so a stale word never leaks into a back-to-back refused read
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_hrdata <= 32'h00000000;
    end else begin
      o_hrdata <= next_hrdata;
    end
  end

endmodule
`default_nettype wire

/* File: twi_regs_props.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// port checker
// ----------------------------------------
module twi_regs_props
  import twi_status_pkg::*;
(
  // watched ports
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic i_tx_taken,
  input wire engine_levels_t i_levels,
  input wire logic [7:0] o_byte_to_send,
  input wire logic o_byte_valid
);
  logic rd_st;
  logic wr_tx;
  wire logic take = i_hready && i_hsel && i_htrans[1];
  // data phase markers, one cycle after the address phase
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      rd_st <= 1'b0;
      wr_tx <= 1'b0;
    end else begin
      rd_st <= take && !i_hwrite && i_haddr[7:0] == ADDR_STATUS;
      wr_tx <= take && i_hwrite && i_hsize == 3'h2 && i_haddr[7:0] == ADDR_TX_HOLDING;
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  // levels held still so the image latency cannot blur the check
  sequence s_steady_read;
    rd_st && $past(i_levels, 1) == $past(i_levels, 2) && $past(i_levels, 2) == $past(i_levels, 3);
  endsequence
  sequence s_tx_write;
    wr_tx && !i_tx_taken;
  endsequence
  a_enable_shown: assert property (s_steady_read |-> o_hrdata[16] == $past(i_levels.master_enabled, 2))
    else $error("enable bit wrong");
  a_bus_free_live: assert property (s_steady_read |-> o_hrdata[5] == $past(i_levels.bus_free, 2))
    else $error("bus free bit wrong");
  a_idle_live: assert property (s_steady_read |->
    o_hrdata[4] == !($past(i_levels.command_busy, 2) || $past(i_levels.command_queued, 2)))
    else $error("idle bit wrong");
  a_slot_ready: assert property (s_steady_read |-> o_hrdata[2] == $past(i_levels.command_slot_free, 2))
    else $error("command ready bit wrong");
  a_tx_ready_live: assert property (s_steady_read |->
    o_hrdata[1] == ($past(i_levels.tx_room, 2) && !$past(i_levels.tx_stopped, 2)))
    else $error("transmit ready bit wrong");
  a_rx_ready_live: assert property (s_steady_read |-> o_hrdata[0] == $past(i_levels.rx_waiting, 2))
    else $error("receive ready bit wrong");
  a_tx_byte_load: assert property (s_tx_write |=> o_byte_valid && o_byte_to_send == $past(i_hwdata[7:0]))
    else $error("transmit byte not loaded");
  a_tx_byte_taken: assert property (i_tx_taken && !wr_tx |=> !o_byte_valid)
    else $error("transmit byte not released");
endmodule
bind twi_master_status_irq_regs twi_regs_props i_props (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_hsel(i_hsel),
  .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
  .i_hready(i_hready), .o_hrdata(o_hrdata), .i_tx_taken(i_tx_taken), .i_levels(i_levels),
  .o_byte_to_send(o_byte_to_send), .o_byte_valid(o_byte_valid));
`default_nettype wire

/* File: twi_engine_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// far side byte consumer
// ----------------------------------------
module twi_engine_model (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // byte handoff
  input wire logic i_byte_valid,
  input wire logic [3:0] i_delay,
  output logic o_taken
);
  logic [3:0] wait_count;
  // takes a byte after a chosen delay; one-cycle pulse so no byte is eaten twice
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      wait_count <= 4'h0;
      o_taken <= 1'b0;
    end else begin
      o_taken <= i_byte_valid && !o_taken && wait_count == i_delay;
      wait_count <= (i_byte_valid && !o_taken && wait_count != i_delay) ? wait_count + 4'h1 : 4'h0;
    end
  end
endmodule
`default_nettype wire

/* File: twi_master_status_irq_regs_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module twi_master_status_irq_regs_tb import twi_status_pkg::*;;
  logic i_mclk = 1'b0, i_rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, bsamp = 1'b0, sda_in = 1'b1;
  logic oe_n = 1'b1, sda_o = 1'b1, hready, hresp, bvalid, taken, irq;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, got, lfsr = 32'hBF98;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [3:0] delay = 4'h0;
  logic [7:0] byte_out;
  engine_events_t ev = '0;
  engine_levels_t lv = '0;
  int num_errors = 0, check_count = 0, cycles = 0;
  int pos [7] = '{3, 9, 8, 11, 12, 13, 14};
  always #12.5 i_mclk = ~i_mclk;
  twi_master_status_irq_regs i_dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .i_events(ev), .i_levels(lv),
    .i_tx_taken(taken), .i_sda_sample(sda_in), .i_sda_oe_n(oe_n), .i_sda_out(sda_o),
    .i_bit_sample(bsamp), .o_byte_to_send(byte_out), .o_byte_valid(bvalid), .o_irq(irq));
  twi_engine_model i_model (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_byte_valid(bvalid), .i_delay(delay),
    .o_taken(taken));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] exp_status(input engine_levels_t l);
    return {15'h0, l.master_enabled, 10'h0, l.bus_free, !(l.command_busy || l.command_queued), 1'b0,
      l.command_slot_free, l.tx_room && !l.tx_stopped, l.rx_waiting};
  endfunction
  // one single ahb transfer; waits on hready at both phases
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [2:0] sz);
    @(posedge i_mclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= sz;
    do @(posedge i_mclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge i_mclk); while (hready !== 1'b1);
    got = hrdata;
    hsel <= 1'b0;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_bit(input logic g, input logic e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one sampled data bit, driving drv_lvl while the wire shows wire_lvl
  task automatic arb_bit(input logic drv_lvl, input logic wire_lvl);
    @(posedge i_mclk);
    oe_n <= 1'b0;
    sda_o <= drv_lvl;
    sda_in <= wire_lvl;
    bsamp <= 1'b1;
    @(posedge i_mclk);
    bsamp <= 1'b0;
    oe_n <= 1'b1;
    sda_o <= 1'b1;
    sda_in <= 1'b1;
    repeat (3) @(posedge i_mclk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge i_mclk);
    i_rstn <= 1'b1;
    bus(1'b0, ADDR_IRQ_MASK, 32'h0, 3'h2);
    cmp(got, IRQ_MASK_RESET);
    bus(1'b1, 8'h30, 32'hFFFFFFFF, 3'h2);
    bus(1'b1, ADDR_IRQ_MASK, 32'hFFFFFFFF, 3'h2);
    bus(1'b0, ADDR_IRQ_MASK, 32'h0, 3'h2);
    cmp(got, 32'h0);
    bus(1'b0, 8'h30, 32'h0, 3'h2);
    cmp(got, 32'h0);
    cmp_bit(hresp, 1'b0);
    $display("reset and refusal test done");
    repeat (8) begin
      lfsr = next_rand(lfsr);
      lv <= engine_levels_t'(lfsr[7:0]);
      repeat (3) @(posedge i_mclk);
      bus(1'b0, ADDR_STATUS, 32'h0, 3'h2);
      cmp(got, exp_status(lv));
    end
    $display("live level test done");
    lv <= '0;
    for (int i = 0; i < 7; i++) begin
      bus(1'b1, ADDR_IRQ_ENABLE_SET, 32'h1 << pos[i], 3'h2);
      bus(1'b0, ADDR_IRQ_MASK, 32'h0, 3'h2);
      cmp(got, 32'h1 << pos[i]);
      ev <= engine_events_t'(7'h01 << i);
      @(posedge i_mclk);
      ev <= '0;
      repeat (4) @(posedge i_mclk);
      cmp_bit(irq, 1'b1);
      bus(1'b1, ADDR_IRQ_ENABLE_CLEAR, 32'hFFFFFFFF, 3'h2);
      repeat (3) @(posedge i_mclk);
      cmp_bit(irq, 1'b0);
      bus(1'b1, ADDR_STATUS_CLEAR, ~(32'h1 << pos[i]), 3'h2);
      bus(1'b0, ADDR_STATUS, 32'h0, 3'h2);
      cmp(got, 32'h10 | (32'h1 << pos[i]));
      bus(1'b1, ADDR_STATUS_CLEAR, 32'h1 << pos[i], 3'h2);
      bus(1'b0, ADDR_STATUS, 32'h0, 3'h2);
      cmp(got, 32'h10);
    end
    $display("sticky flag test done");
    arb_bit(1'b1, 1'b1);
    bus(1'b0, ADDR_STATUS, 32'h0, 3'h2);
    cmp(got, 32'h10);
    arb_bit(1'b0, 1'b0);
    bus(1'b0, ADDR_STATUS, 32'h0, 3'h2);
    cmp(got, 32'h10);
    arb_bit(1'b1, 1'b0);
    bus(1'b0, ADDR_STATUS, 32'h0, 3'h2);
    cmp(got, 32'h410);
    bus(1'b1, ADDR_STATUS_CLEAR, 32'h400, 3'h2);
    $display("arbitration test done");
    for (int i = 0; i < 4; i++) begin
      lfsr = next_rand(lfsr);
      delay <= lfsr[11:8];
      bus(1'b1, ADDR_TX_HOLDING, lfsr, 3'h2);
      @(posedge i_mclk);
      cmp({24'h0, byte_out}, {24'h0, lfsr[7:0]});
      cmp_bit(bvalid, 1'b1);
      repeat (20) @(posedge i_mclk);
      cmp_bit(bvalid, 1'b0);
    end
    $display("transmit byte test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
